// ==== rtl/energy_accumulation_control.sv ====
// energy accumulation control: registers, crossing count, energy bank, power factor source
// Summary of operation
// - wiring field picks phase voltages; code 11 uses negated phase a for b
// - code 01 uses phase a minus phase c as phase b voltage
// - three-wire mode puts the a-to-c line rms into the phase b rms register
// - three-wire mode forces phase b current to zero, so b powers are zero
// - mode bit 0 picks regular or line cycle for active energies, resets 0
// - mode bit 1 picks regular or line cycle for reactive energies, resets 0
// - mode bit 2 picks regular or line cycle for apparent energies, resets 0
// - mode bits 3 to 5 enable phase a, b, c crossings; each resets 1
// - crossings of all enabled phases are counted, shortening the period
// - mode bit 6 set makes a read of an energy register clear it
// - mode bit 7 at 0 takes power factor from instantaneous powers
// - mode bit 7 at 1 takes power factor from line cycle energies per period
// - reactive inputs use the quadrature shifted current times voltage
// - wiring codes: 00 four-wire, 01 three-wire, 11 four-wire delta, resets 00
module energy_accumulation_control
  import energy_ctrl_pkg::*;
#(
  parameter int SW = 24,
  parameter int EW = 32
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [energy_ctrl_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [energy_ctrl_pkg::DATA_W-1:0] writedata,
  output logic [energy_ctrl_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic sample_valid,
  input wire logic signed [energy_ctrl_pkg::PHASES-1:0][SW-1:0] volt,
  input wire logic signed [energy_ctrl_pkg::PHASES-1:0][SW-1:0] curr,
  input wire logic signed [energy_ctrl_pkg::PHASES-1:0][SW-1:0] curr_q,
  input wire logic signed [energy_ctrl_pkg::PHASES-1:0][SW-1:0] fund_curr,
  input wire logic signed [energy_ctrl_pkg::PHASES-1:0][SW-1:0] fund_curr_q,
  input wire logic [energy_ctrl_pkg::PHASES-1:0][SW-1:0] volt_rms,
  input wire logic [energy_ctrl_pkg::PHASES-1:0][SW-1:0] curr_rms,
  input wire logic [SW-1:0] line_ac_rms,
  input wire logic [energy_ctrl_pkg::PHASES-1:0] zero_cross,
  output logic [SW-1:0] phase_b_voltage_rms,
  output logic [2:0] freq_out1_term_select,
  output logic [2:0] freq_out2_term_select,
  output logic [2:0] freq_out3_term_select,
  output logic [energy_ctrl_pkg::PHASES-1:0][EW-1:0] pf_active,
  output logic [energy_ctrl_pkg::PHASES-1:0][EW-1:0] pf_apparent,
  output logic pf_valid,
  output logic period_end
);
  import energy_ctrl_pkg::*;

  logic [7:0] line_cycle_mode_control;
  logic [10:0] computation_mode_control;
  logic [15:0] half_cycle_count;
  logic [15:0] cross_total;
  logic [16:0] next_cross_total;
  logic [1:0] cross_hits;
  logic [PHASES-1:0] cross_enabled;
  logic [15:0] word_index;
  logic rd_capture, wr_fire, period_done;
  logic [1:0] wiring_config_select;
  logic active_cycle_accum_en, reactive_cycle_accum_en, apparent_cycle_accum_en;
  logic [2:0] crossing_phase_select;
  logic clear_on_read_en, power_factor_source;
  logic [ENTRIES-1:0][EW-1:0] power;
  logic [ENTRIES-1:0][EW-1:0] energy;
  logic [ENTRIES-1:0] entry_line_mode;
  logic [SW-1:0] vrms_b;
  logic [DATA_W-1:0] next_readdata;
  logic pf_load;

  assign word_index = address[ADDR_W-1:2];
  assign rd_capture = read && waitrequest;
  assign wr_fire = write && !waitrequest;
  assign active_cycle_accum_en = line_cycle_mode_control[ACTIVE_BIT];
  assign reactive_cycle_accum_en = line_cycle_mode_control[REACTIVE_BIT];
  assign apparent_cycle_accum_en = line_cycle_mode_control[APPARENT_BIT];
  assign crossing_phase_select = line_cycle_mode_control[CROSS_LSB +: 3];
  assign clear_on_read_en = line_cycle_mode_control[CLEAR_READ_BIT];
  assign power_factor_source = line_cycle_mode_control[PF_SOURCE_BIT];
  assign wiring_config_select = computation_mode_control[WIRING_LSB +: 2];

  ////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, data captured as waitrequest drops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  always_comb begin
    next_readdata = '0;
    if (word_index == MODE_INDEX) begin
      next_readdata = {24'h000000, line_cycle_mode_control};
    end else if (word_index == COMP_INDEX) begin
      next_readdata = {21'h000000, computation_mode_control};
    end else if (word_index == CYCLE_INDEX) begin
      next_readdata = {16'h0000, half_cycle_count};
    end else if (word_index == VRMS_B_INDEX) begin
      next_readdata = DATA_W'(phase_b_voltage_rms);
    end else if (word_index >= ENERGY_INDEX && word_index < ENERGY_INDEX + 16'(ENTRIES)) begin
      next_readdata = DATA_W'(energy[4'(word_index - ENERGY_INDEX)]);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= '0;
    end else if (rd_capture) begin
      readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_cycle_mode_control <= MODE_RESET;
    end else if (wr_fire && word_index == MODE_INDEX) begin
      line_cycle_mode_control <= writedata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      computation_mode_control <= COMP_RESET;
    end else if (wr_fire && word_index == COMP_INDEX) begin
      computation_mode_control <= writedata[10:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      half_cycle_count <= CYCLE_RESET;
    end else if (wr_fire && word_index == CYCLE_INDEX) begin
      half_cycle_count <= writedata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_out1_term_select <= COMP_RESET[TERM1_LSB +: 3];
      freq_out2_term_select <= COMP_RESET[TERM2_LSB +: 3];
      freq_out3_term_select <= COMP_RESET[TERM3_LSB +: 3];
    end else begin
      freq_out1_term_select <= computation_mode_control[TERM1_LSB +: 3];
      freq_out2_term_select <= computation_mode_control[TERM2_LSB +: 3];
      freq_out3_term_select <= computation_mode_control[TERM3_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////
  // count all enabled crossings
  assign cross_enabled = zero_cross & crossing_phase_select;
  assign cross_hits = 2'(cross_enabled[0]) + 2'(cross_enabled[1]) + 2'(cross_enabled[2]);
  assign next_cross_total = 17'(cross_total) + 17'(cross_hits);
  assign period_done = (cross_hits != 2'h0) && (next_cross_total >= 17'(half_cycle_count));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cross_total <= '0;
      period_end <= 1'b0;
    end else begin
      period_end <= period_done;
      cross_total <= period_done ? 16'h0000 : next_cross_total[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // energy bank
  power_source_select #(.SW(SW), .EW(EW)) u_select (
    .wiring(wiring_config_select),
    .volt(volt),
    .curr(curr),
    .curr_q(curr_q),
    .fund_curr(fund_curr),
    .fund_curr_q(fund_curr_q),
    .volt_rms(volt_rms),
    .curr_rms(curr_rms),
    .line_ac_rms(line_ac_rms),
    .power(power),
    .vrms_b(vrms_b)
  );

  genvar k;
  generate
    for (k = 0; k < ENTRIES; k++) begin : g_energy
      if (k / PHASES == KIND_VA) begin : g_va
        assign entry_line_mode[k] = apparent_cycle_accum_en;
      end else if (k / PHASES == KIND_VAR || k / PHASES == KIND_FVAR) begin : g_var
        assign entry_line_mode[k] = reactive_cycle_accum_en;
      end else begin : g_watt
        assign entry_line_mode[k] = active_cycle_accum_en;
      end
      energy_accumulator #(.EW(EW)) u_acc (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .power(power[k]),
        .sample_valid(sample_valid),
        .line_mode(entry_line_mode[k]),
        .period_end(period_end),
        .clear_req(rd_capture && clear_on_read_en && word_index == ENERGY_INDEX + 16'(k)),
        .energy(energy[k])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_b_voltage_rms <= '0;
    end else if (sample_valid) begin
      phase_b_voltage_rms <= vrms_b;
    end
  end

  ////////////////////////////////////////////////////////////////
  // power factor operands, the divider sits outside
  // energies load at period end, operands follow one cycle later
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pf_load <= 1'b0;
    end else begin
      pf_load <= period_end;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pf_active <= '0;
      pf_apparent <= '0;
      pf_valid <= 1'b0;
    end else if (power_factor_source) begin
      // line cycle energies once per period
      pf_valid <= pf_load;
      if (pf_load) begin
        for (int p = 0; p < PHASES; p++) begin
          pf_active[p] <= energy[KIND_WATT*PHASES+p];
          pf_apparent[p] <= energy[KIND_VA*PHASES+p];
        end
      end
    end else begin
      pf_valid <= sample_valid;
      if (sample_valid) begin
        for (int p = 0; p < PHASES; p++) begin
          pf_active[p] <= power[KIND_WATT*PHASES+p];
          pf_apparent[p] <= power[KIND_VA*PHASES+p];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  mode_reset_a: assert property (@(posedge ref_clk) $rose(rst_b) |-> line_cycle_mode_control == 8'h78)
    else $error("mode register reset value wrong");
  line_watt_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    active_cycle_accum_en && $past(active_cycle_accum_en) && !period_end && !rd_capture |=> $stable(energy[0]))
    else $error("line cycle active energy moved outside period end");
  line_var_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reactive_cycle_accum_en && $past(reactive_cycle_accum_en) && !period_end && !rd_capture |=> $stable(energy[3]))
    else $error("line cycle reactive energy moved outside period end");
  line_va_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    apparent_cycle_accum_en && $past(apparent_cycle_accum_en) && !period_end && !rd_capture |=> $stable(energy[6]))
    else $error("line cycle apparent energy moved outside period end");
  read_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rd_capture && clear_on_read_en && !active_cycle_accum_en && !sample_valid && word_index == ENERGY_INDEX
    |=> energy[0] == '0)
    else $error("read did not clear energy");
  read_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rd_capture && !clear_on_read_en && !active_cycle_accum_en && !sample_valid |=> $stable(energy[0]))
    else $error("read changed energy with clearing off");
  period_count_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    period_end |-> $past(17'(cross_total) + 17'(cross_hits)) >= 17'($past(half_cycle_count)) && cross_total == 0)
    else $error("period ended before enough crossings");
  pf_inst_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !power_factor_source && sample_valid |=> pf_valid && pf_active[0] == $past(power[0]))
    else $error("instantaneous power factor operand wrong");
  pf_line_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    power_factor_source && $past(power_factor_source) |-> pf_valid == $past(period_end, 2))
    else $error("line cycle power factor update off period");
  b_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wiring_config_select == 2'h1 |-> power[1] == '0 && power[4] == '0 && power[7] == '0)
    else $error("phase b power not zero in three-wire");
  b_rms_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wiring_config_select == 2'h1 && sample_valid |=> phase_b_voltage_rms == $past(line_ac_rms))
    else $error("phase b rms not line rms");
  bus_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest sequence wrong");
  period_cov: cover property (@(posedge ref_clk) disable iff (!rst_b) period_end && active_cycle_accum_en);
  clear_cov: cover property (@(posedge ref_clk) disable iff (!rst_b) rd_capture && clear_on_read_en);
  delta_cov: cover property (@(posedge ref_clk) disable iff (!rst_b) wiring_config_select == 2'h3 && sample_valid);
  pf_cov: cover property (@(posedge ref_clk) disable iff (!rst_b) pf_valid && power_factor_source);
endmodule // energy_accumulation_control

// ==== rtl/energy_ctrl_pkg.sv ====
// constants and types shared by the energy accumulation control block
package energy_ctrl_pkg;
  // register word indexes, byte address is four times the index
  localparam logic [15:0] MODE_INDEX = 16'hE702;
  localparam logic [15:0] COMP_INDEX = 16'hE710;
  localparam logic [15:0] CYCLE_INDEX = 16'hE711;
  localparam logic [15:0] VRMS_B_INDEX = 16'hE712;
  localparam logic [15:0] ENERGY_INDEX = 16'hE720;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  // line cycle mode control fields
  localparam int ACTIVE_BIT = 0;
  localparam int REACTIVE_BIT = 1;
  localparam int APPARENT_BIT = 2;
  localparam int CROSS_LSB = 3;
  localparam int CLEAR_READ_BIT = 6;
  localparam int PF_SOURCE_BIT = 7;
  localparam logic [7:0] MODE_RESET = 8'h78;
  // computation mode control fields
  localparam int TERM1_LSB = 0;
  localparam int TERM2_LSB = 3;
  localparam int TERM3_LSB = 6;
  localparam int WIRING_LSB = 9;
  localparam logic [10:0] COMP_RESET = 11'h1FF;
  localparam logic [15:0] CYCLE_RESET = 16'h0064;
  // energy entries: kind times three plus phase
  localparam int PHASES = 3;
  localparam int ENTRIES = 15;
  localparam int KIND_WATT = 0;
  localparam int KIND_VAR = 1;
  localparam int KIND_VA = 2;
  localparam int KIND_FWATT = 3;
  localparam int KIND_FVAR = 4;
  typedef enum logic [1:0] {
    FOUR_WIRE = 2'b00,
    THREE_WIRE_DELTA = 2'b01,
    WIRING_RESERVED = 2'b10,
    FOUR_WIRE_DELTA = 2'b11
  } wiring_type;
endpackage

// ==== rtl/power_source_select.sv ====
// per phase power products chosen by the wiring arrangement
module power_source_select
  import energy_ctrl_pkg::*;
#(
  parameter int SW = 24,
  parameter int EW = 32
) (
  input wire logic [1:0] wiring,
  input wire logic signed [PHASES-1:0][SW-1:0] volt,
  input wire logic signed [PHASES-1:0][SW-1:0] curr,
  input wire logic signed [PHASES-1:0][SW-1:0] curr_q,
  input wire logic signed [PHASES-1:0][SW-1:0] fund_curr,
  input wire logic signed [PHASES-1:0][SW-1:0] fund_curr_q,
  input wire logic [PHASES-1:0][SW-1:0] volt_rms,
  input wire logic [PHASES-1:0][SW-1:0] curr_rms,
  input wire logic [SW-1:0] line_ac_rms,
  output logic [ENTRIES-1:0][EW-1:0] power,
  output logic [SW-1:0] vrms_b
);
  logic signed [PHASES-1:0][SW:0] vsel;
  logic signed [PHASES-1:0][SW-1:0] isel, iqsel, fisel, fiqsel;
  logic signed [SW:0] va_ext, vc_ext;
  logic [PHASES-1:0][SW-1:0] vrsel, irsel;

  assign va_ext = {volt[0][SW-1], volt[0]};
  assign vc_ext = {volt[2][SW-1], volt[2]};

  ////////////////////////////////////////////////////////////////
  always_comb begin
    for (int p = 0; p < PHASES; p++) begin
      vsel[p] = {volt[p][SW-1], volt[p]};
      isel[p] = curr[p];
      iqsel[p] = curr_q[p];
      fisel[p] = fund_curr[p];
      fiqsel[p] = fund_curr_q[p];
      vrsel[p] = volt_rms[p];
      irsel[p] = curr_rms[p];
    end
    case (wiring)
      THREE_WIRE_DELTA: begin
        vsel[1] = va_ext - vc_ext;
        isel[1] = '0;
        iqsel[1] = '0;
        fisel[1] = '0;
        fiqsel[1] = '0;
        irsel[1] = '0;
        vrsel[1] = line_ac_rms;
      end
      FOUR_WIRE_DELTA: begin
        vsel[1] = -va_ext;
        vrsel[1] = volt_rms[0];
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < PHASES; g++) begin : g_phase
      logic signed [2*SW:0] p_w, p_v, p_fw, p_fv;
      logic [2*SW-1:0] p_s;
      // element selects of packed arrays are unsigned, so cast back
      assign p_w = $signed(vsel[g]) * $signed(isel[g]);
      assign p_v = $signed(vsel[g]) * $signed(iqsel[g]);
      assign p_fw = $signed(vsel[g]) * $signed(fisel[g]);
      assign p_fv = $signed(vsel[g]) * $signed(fiqsel[g]);
      assign p_s = vrsel[g] * irsel[g];
      assign power[KIND_WATT*PHASES+g] = p_w[2*SW-1 -: EW];
      assign power[KIND_VAR*PHASES+g] = p_v[2*SW-1 -: EW];
      assign power[KIND_VA*PHASES+g] = p_s[2*SW-1 -: EW];
      assign power[KIND_FWATT*PHASES+g] = p_fw[2*SW-1 -: EW];
      assign power[KIND_FVAR*PHASES+g] = p_fv[2*SW-1 -: EW];
    end
  endgenerate

  assign vrms_b = vrsel[1];
endmodule // power_source_select

// ==== rtl/energy_accumulator.sv ====
// one energy register with regular and line cycle accumulation
module energy_accumulator #(
  parameter int EW = 32
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [EW-1:0] power,
  input wire logic sample_valid,
  input wire logic line_mode,
  input wire logic period_end,
  input wire logic clear_req,
  output logic [EW-1:0] energy
);
  logic [EW-1:0] working;
  logic [EW-1:0] add_term;

  assign add_term = sample_valid ? power : '0;

  ////////////////////////////////////////////////////////////////
  // line cycle partial sum
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      working <= '0;
    end else if (!line_mode || period_end) begin
      working <= '0;
    end else begin
      working <= working + add_term;
    end
  end

  // visible register, a sample in the clearing cycle is kept
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      energy <= '0;
    end else if (line_mode) begin
      if (period_end) begin
        energy <= working + add_term;
      end else if (clear_req) begin
        energy <= '0;
      end
    end else if (clear_req) begin
      energy <= add_term;
    end else begin
      energy <= energy + add_term;
    end
  end
endmodule // energy_accumulator

// ==== dv/energy_accumulation_control_tb.sv ====
// self-checking testbench for the energy accumulation control block
module energy_accumulation_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import energy_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic sample_valid = 1'b0;
  logic signed [PHASES-1:0][23:0] volt = '0, curr = '0, curr_q = '0, fund_curr = '0, fund_curr_q = '0;
  logic [PHASES-1:0][23:0] volt_rms = '0, curr_rms = '0;
  logic [23:0] line_ac_rms = '0;
  logic [PHASES-1:0] zero_cross = '0;
  logic [23:0] phase_b_voltage_rms;
  logic [2:0] freq_out1_term_select, freq_out2_term_select, freq_out3_term_select;
  logic [PHASES-1:0][31:0] pf_active, pf_apparent;
  logic pf_valid, period_end;
  logic signed [23:0] v[3], c[3], q[3], f[3], fq[3];
  logic [23:0] vr[3], cr[3], lr;
  int err_total = 0, comparisons = 0, cyc = 0, pe_cnt = 0, pf_cnt = 0, seed = 65850;
  energy_accumulation_control u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .sample_valid(sample_valid), .volt(volt), .curr(curr), .curr_q(curr_q), .fund_curr(fund_curr),
    .fund_curr_q(fund_curr_q), .volt_rms(volt_rms), .curr_rms(curr_rms), .line_ac_rms(line_ac_rms),
    .zero_cross(zero_cross), .phase_b_voltage_rms(phase_b_voltage_rms),
    .freq_out1_term_select(freq_out1_term_select), .freq_out2_term_select(freq_out2_term_select),
    .freq_out3_term_select(freq_out3_term_select), .pf_active(pf_active), .pf_apparent(pf_apparent),
    .pf_valid(pf_valid), .period_end(period_end));
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (period_end === 1'b1) pe_cnt++;
    if (pf_valid === 1'b1) pf_cnt++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] pw(input logic signed [24:0] a, input logic signed [23:0] b);
    logic signed [48:0] t;
    t = a * b;
    return t[47:16];
  endfunction
  function automatic logic [31:0] pu(input logic [23:0] a, input logic [23:0] b);
    logic [47:0] t;
    t = a * b;
    return t[47:16];
  endfunction
  function automatic logic [31:0] ee(input int k, input logic [1:0] w);
    logic signed [24:0] vb;
    logic [23:0] rb;
    vb = (w == 2'b00) ? v[1] : (w == 2'b11) ? -v[0] : v[0] - v[2];
    rb = (w == 2'b00) ? vr[1] : (w == 2'b11) ? vr[0] : lr;
    case (k)
      0, 2: return pw(v[k], c[k]);
      1: return (w == 2'b01) ? 32'h0 : pw(vb, c[1]);
      3, 5: return pw(v[k-3], q[k-3]);
      4: return (w == 2'b01) ? 32'h0 : pw(vb, q[1]);
      6, 8: return pu(vr[k-6], cr[k-6]);
      7: return (w == 2'b01) ? 32'h0 : pu(rb, cr[1]);
      9, 11: return pw(v[k-9], f[k-9]);
      10: return (w == 2'b01) ? 32'h0 : pw(vb, f[1]);
      12, 14: return pw(v[k-12], fq[k-12]);
      default: return (w == 2'b01) ? 32'h0 : pw(vb, fq[1]);
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    address <= {idx, 2'b00};
    write <= w;
    read <= !w;
    writedata <= wd;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [31:0] exp, input string m);
    logic [31:0] d;
    bus(1'b0, idx, 32'h0, d);
    chk(d, exp, m);
  endtask
  task automatic samp();
    for (int p = 0; p < 3; p++) begin
      v[p] = $random(seed);
      c[p] = $random(seed);
      q[p] = $random(seed);
      vr[p] = $random(seed);
      cr[p] = $random(seed);
      f[p] = $random(seed);
      fq[p] = $random(seed);
      fund_curr[p] <= f[p];
      fund_curr_q[p] <= fq[p];
      volt[p] <= v[p];
      curr[p] <= c[p];
      curr_q[p] <= q[p];
      volt_rms[p] <= vr[p];
      curr_rms[p] <= cr[p];
    end
    lr = $random(seed);
    line_ac_rms <= lr;
    sample_valid <= 1'b1;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic xz(input logic [2:0] z);
    zero_cross <= z;
    @(posedge ref_clk);
    zero_cross <= 3'b000;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] w;
    logic [8:0] t;
    logic [31:0] sa, sq, sv, old;
    int pe0, pf0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rchk(MODE_INDEX, 32'h78, "mode reset");
    rchk(COMP_INDEX, {21'h0, COMP_RESET}, "comp reset");
    rchk(16'h0001, 32'h0, "unmapped read");
    chk({29'h0, freq_out2_term_select}, 32'h7, "term reset");
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 2'b00 : (i == 1) ? 2'b01 : 2'b11;
      t = $random(seed);
      // term bit 1 cleared in three-wire mode
      if (w == 2'b01) t = t & 9'h16D;
      wr(COMP_INDEX, {21'h0, w, t});
      @(posedge ref_clk);
      chk({23'h0, freq_out3_term_select, freq_out2_term_select, freq_out1_term_select}, {23'h0, t}, "terms");
      samp();
      chk({8'h0, phase_b_voltage_rms}, {8'h0, (w == 2'b01) ? lr : (w == 2'b11) ? vr[0] : vr[1]}, "vrms b");
      for (int k = 0; k < ENTRIES; k++) begin
        rchk(ENERGY_INDEX + 16'(k), ee(k, w), "energy");
      end
      rchk(ENERGY_INDEX, 32'h0, "cleared by read");
      $display("test wiring %b done", w);
    end
    wr(MODE_INDEX, 32'h38);
    samp();
    chk(pf_active[0], pw(v[0], c[0]), "pf instantaneous");
    chk(pf_apparent[0], pu(vr[0], cr[0]), "pf instantaneous va");
    rchk(ENERGY_INDEX, pw(v[0], c[0]), "no clear first");
    rchk(ENERGY_INDEX, pw(v[0], c[0]), "no clear second");
    $display("test read without clear done");
    wr(CYCLE_INDEX, 32'h3);
    // all line cycle bits set and bit 6 left clear so clear on read stays off, pf source set last
    wr(MODE_INDEX, 32'h3F);
    wr(MODE_INDEX, 32'hBF);
    xz(3'b111);
    rchk(ENERGY_INDEX, 32'h0, "empty period");
    bus(1'b0, ENERGY_INDEX, 32'h0, old);
    pe0 = pe_cnt;
    pf0 = pf_cnt;
    samp();
    {sa, sq, sv} = {ee(0, 2'b00), ee(3, 2'b00), ee(6, 2'b00)};
    samp();
    sa += ee(0, 2'b00);
    sq += ee(3, 2'b00);
    sv += ee(6, 2'b00);
    rchk(ENERGY_INDEX, old, "held until period end");
    chk(pf_cnt, pf0, "no pf update mid period");
    xz(3'b001);
    chk(pe_cnt, pe0, "no early period end");
    xz(3'b110);
    chk(pe_cnt, pe0 + 1, "period end by all phases");
    chk(pf_cnt, pf0 + 1, "pf per period");
    chk(pf_active[0], sa, "pf line active");
    chk(pf_apparent[0], sv, "pf line apparent");
    rchk(ENERGY_INDEX, sa, "line active");
    rchk(ENERGY_INDEX + 16'd3, sq, "line reactive");
    rchk(ENERGY_INDEX + 16'd6, sv, "line apparent");
    $display("test line cycle done");
    wr(MODE_INDEX, 32'hA7);
    pe0 = pe_cnt;
    repeat (3) xz(3'b011);
    chk(pe_cnt, pe0, "disabled phases ignored");
    repeat (3) xz(3'b100);
    chk(pe_cnt, pe0 + 1, "enabled phase counted");
    $display("test crossing select done");
    wrap_up();
  end
endmodule // energy_accumulation_control_tb
